/* File: core/i2c_gpio_expander_core.sv */
// Contract
// - sixteen lines in two banks of eight, each bank its own registers
// - direction bits pick input or output; data kept in holding registers
// - input reads invert where the line's invert bit is set
// - keeper or pulls per bank, never both; pulls only without keeper
// - keeper holds undriven line at last driven level; drivers override
// - direction bit one is read, zero is write
// - fixed address, or strap variant uses four address select inputs
// - first byte after address ack is captured as register pointer
// - low four pointer bits select one of sixteen registers
// - command bytes with reserved bits set are not acknowledged
// - pointer resets to zero, auto-advance off
// - auto-advance on: index steps by one after each data byte
// - index wraps from last register to register zero
// - auto-advance off: index stays put after each byte
// - indices 0 and 1 are read-only bank input levels
// - indices 12 and 13 are read/write alert masks
// - indices 14 and 15 are read-only alert flags, writes ignored
// - write is address, command byte, then data into selected register
// - a write changes only the selected register
// - alert output is open-drain, pulled low while asserted
// - active-low hardware reset input resets the device
// - reset makes all lines inputs, restores registers and bus state
// - unmasked input change raises alert; all masked after reset
// - read is address, command, repeated start, address with read bit
// - writes to input registers acked but discarded; levels stay live
`timescale 1ns/1ps
`default_nettype none

module i2c_gpio_expander_core
  import expander_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // straps and hardware reset pin
  input wire logic hw_reset_n_in,
  input wire logic variant_28pin_in,
  input wire logic addr_select_0_in,
  input wire logic addr_select_1_in,
  input wire logic addr_select_2_in,
  input wire logic addr_select_3_in,
  // serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // bank 0 pads
  input wire logic [7:0] bank0_line_in,
  output logic [7:0] bank0_line_out,
  output logic [7:0] bank0_line_oe_n_out,
  output logic [7:0] bank0_hold_en_out,
  output logic [7:0] bank0_hold_level_out,
  output logic [7:0] bank0_pull_up_en_out,
  output logic [7:0] bank0_pull_down_en_out,
  // bank 1 pads
  input wire logic [7:0] bank1_line_in,
  output logic [7:0] bank1_line_out,
  output logic [7:0] bank1_line_oe_n_out,
  output logic [7:0] bank1_hold_en_out,
  output logic [7:0] bank1_hold_level_out,
  output logic [7:0] bank1_pull_up_en_out,
  output logic [7:0] bank1_pull_down_en_out,
  // alert pin, open drain
  output logic int_out,
  output logic int_oe_n_out
);

  logic [SYNC_WIDTH-1:0] raw, s1_q, s2_q, s3_q, filt_q;
  logic hw_rst_active, scl_f, sda_f, scl_prev_q, sda_prev_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [6:0] slave_addr;
  logic [15:0] pins, pins_prev_q, dir_v, drive_v, mask_v, inv_v, pdir_v;
  logic [15:0] keep_v, pull_v, flags_q, set_v, clr_v;
  logic [7:0] regs_q [NUM_LINES];
  logic [7:0] ptr_q, rx_q, tx_q, rd_byte;
  logic [3:0] idx, cnt_q;
  logic cmd_ok, cmd_take, wr_commit, rd_commit, rd_load, rw_q, sda_oe_n_q;
  logic [15:0] line_out_q, line_oe_n_q, hold_en_q, hold_q, pu_q, pd_q;
  logic int_oe_n_q, int_low_q;
  xfer_state_t state_q;

  assign raw = {hw_reset_n_in, variant_28pin_in, addr_select_3_in,
                addr_select_2_in, addr_select_1_in, addr_select_0_in,
                scl_in, sda_in, bank1_line_in, bank0_line_in};

  // a level only counts once the second and third stages agree
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= SYNC_RESET;
      s2_q <= SYNC_RESET;
      s3_q <= SYNC_RESET;
      filt_q <= SYNC_RESET;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
    end
  end

  assign hw_rst_active = ~filt_q[SYNC_HW_RST_BIT];
  assign scl_f = filt_q[SYNC_SCL_BIT];
  assign sda_f = filt_q[SYNC_SDA_BIT];
  assign pins = filt_q[NUM_LINES-1:0];
  assign slave_addr = filt_q[SYNC_VARIANT_BIT]
    ? {STRAP_ADDR_BASE, filt_q[SYNC_ADDR_HI:SYNC_ADDR_LO]}
    : FIXED_SLAVE_ADDR;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  assign scl_rise = scl_f & ~scl_prev_q;
  assign scl_fall = ~scl_f & scl_prev_q;
  assign start_det = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign stop_det = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

  // two banks of eight, low byte is bank 0
  assign inv_v = {regs_q[IDX_READ_INVERT1], regs_q[IDX_READ_INVERT0]};
  assign pdir_v = {regs_q[IDX_PULL_DIR1], regs_q[IDX_PULL_DIR0]};
  assign dir_v = {regs_q[IDX_LINE_DIR1], regs_q[IDX_LINE_DIR0]};
  assign drive_v = {regs_q[IDX_DRIVE_VALUE1], regs_q[IDX_DRIVE_VALUE0]};
  assign mask_v = {regs_q[IDX_ALERT_MASK1], regs_q[IDX_ALERT_MASK0]};
  // keeper wins, pulls only when keeper is off
  assign keep_v = {{BANK_WIDTH{regs_q[IDX_KEEPER_PULL1][KEEPER_EN_BIT]}},
                   {BANK_WIDTH{regs_q[IDX_KEEPER_PULL0][KEEPER_EN_BIT]}}};
  assign pull_v = ~keep_v &
    {{BANK_WIDTH{regs_q[IDX_KEEPER_PULL1][PULL_EN_BIT]}},
     {BANK_WIDTH{regs_q[IDX_KEEPER_PULL0][PULL_EN_BIT]}}};

  assign idx = ptr_q[3:0];
  // reserved bits set means no ack
  assign cmd_ok = (rx_q & CMD_RESERVED_MASK) == BYTE_ZERO;
  assign cmd_take = scl_fall & ~hw_rst_active & state_q == ST_CMD &
                    cnt_q == BIT_COUNT_FULL & cmd_ok;
  assign wr_commit = scl_fall & ~hw_rst_active & state_q == ST_WDATA &
                     cnt_q == BIT_COUNT_FULL;
  assign rd_commit = scl_fall & ~hw_rst_active & state_q == ST_RDATA &
                     cnt_q == BIT_COUNT_FULL;
  assign rd_load = ~hw_rst_active &
    ((scl_fall & state_q == ST_ADDR_ACK & rw_q) |
     (scl_rise & state_q == ST_RDATA_ACK & ~sda_f));

  always_comb begin
    case (idx)
      // live levels through the invert mask
      IDX_PIN_LEVELS0: rd_byte = pins[7:0] ^ inv_v[7:0];
      IDX_PIN_LEVELS1: rd_byte = pins[15:8] ^ inv_v[15:8];
      IDX_ALERT_FLAGS0: rd_byte = flags_q[7:0];
      IDX_ALERT_FLAGS1: rd_byte = flags_q[15:8];
      default: rd_byte = regs_q[idx];
    endcase
  end

  // bus state machine
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      rx_q <= BYTE_ZERO;
      tx_q <= BYTE_ZERO;
      rw_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (hw_rst_active || stop_det) begin
      state_q <= ST_IDLE;
      sda_oe_n_q <= 1'b1;
    end else if (start_det) begin
      // repeated start keeps the pointer for reads
      state_q <= ST_ADDR;
      cnt_q <= '0;
      sda_oe_n_q <= 1'b1;
    end else if (scl_rise) begin
      cnt_q <= cnt_q + BIT_COUNT_ONE;
      rx_q <= {rx_q[6:0], sda_f};
      // master nack ends the read
      if (state_q == ST_RDATA_ACK) begin
        if (sda_f) begin
          state_q <= ST_IDLE;
        end else begin
          tx_q <= rd_byte;
        end
      end
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          if (cnt_q == BIT_COUNT_FULL) begin
            if (rx_q[7:1] == slave_addr) begin
              // last bit picks read or write
              rw_q <= rx_q[0];
              sda_oe_n_q <= 1'b0;
              state_q <= ST_ADDR_ACK;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          cnt_q <= '0;
          if (rw_q) begin
            sda_oe_n_q <= rd_byte[7];
            tx_q <= {rd_byte[6:0], 1'b0};
            state_q <= ST_RDATA;
          end else begin
            sda_oe_n_q <= 1'b1;
            state_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (cnt_q == BIT_COUNT_FULL) begin
            if (cmd_ok) begin
              sda_oe_n_q <= 1'b0;
              state_q <= ST_CMD_ACK;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          sda_oe_n_q <= 1'b1;
          cnt_q <= '0;
          state_q <= ST_WDATA;
        end
        ST_WDATA: begin
          // every data byte acked, even to read-only slots
          if (cnt_q == BIT_COUNT_FULL) begin
            sda_oe_n_q <= 1'b0;
            state_q <= ST_WDATA_ACK;
          end
        end
        ST_RDATA: begin
          if (cnt_q == BIT_COUNT_FULL) begin
            sda_oe_n_q <= 1'b1;
            state_q <= ST_RDATA_ACK;
          end else begin
            sda_oe_n_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
        ST_RDATA_ACK: begin
          cnt_q <= '0;
          sda_oe_n_q <= tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
          state_q <= ST_RDATA;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // register pointer
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_q <= POINTER_RESET;
    end else if (hw_rst_active) begin
      ptr_q <= POINTER_RESET;
    end else if (cmd_take) begin
      ptr_q <= rx_q;
    // step and wrap only with auto-advance
    end else if ((wr_commit || rd_commit) && ptr_q[AUTOADVANCE_BIT]) begin
      ptr_q[3:0] <= ptr_q[3:0] + POINTER_STEP;
    end
  end

  // register file; read-only slots are never written
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        regs_q[i] <= reset_value(4'(i));
      end
    end else if (hw_rst_active) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        regs_q[i] <= reset_value(4'(i));
      end
    end else if (wr_commit && idx >= IDX_READ_INVERT0 &&
                 idx <= IDX_ALERT_MASK1) begin
      regs_q[idx] <= rx_q;
    end
  end

  // unmasked change on an input line
  assign set_v = (pins ^ pins_prev_q) & ~mask_v & dir_v;
  // reading a bank's levels clears that bank's flags
  assign clr_v = {{BANK_WIDTH{rd_load && idx == IDX_PIN_LEVELS1}},
                  {BANK_WIDTH{rd_load && idx == IDX_PIN_LEVELS0}}};

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pins_prev_q <= '0;
      flags_q <= '0;
    end else if (hw_rst_active) begin
      pins_prev_q <= pins;
      flags_q <= '0;
    end else begin
      pins_prev_q <= pins;
      // set beats clear in the same cycle
      flags_q <= (flags_q & ~clr_v) | set_v;
    end
  end

  // pad drive, all from flops
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      line_out_q <= '0;
      line_oe_n_q <= '1;
      hold_en_q <= '0;
      hold_q <= '0;
      pu_q <= '0;
      pd_q <= '0;
      int_oe_n_q <= 1'b1;
      int_low_q <= 1'b0;
    end else begin
      line_out_q <= drive_v;
      line_oe_n_q <= dir_v;
      // keeper tracks the last resolved level
      hold_en_q <= keep_v & dir_v;
      hold_q <= pins;
      pu_q <= pull_v & dir_v & pdir_v;
      pd_q <= pull_v & dir_v & ~pdir_v;
      // pull low while any flag stands
      int_oe_n_q <= ~(|flags_q);
      int_low_q <= 1'b0;
    end
  end

  assign sda_out = int_low_q;
  assign sda_oe_n_out = sda_oe_n_q;
  assign int_out = int_low_q;
  assign int_oe_n_out = int_oe_n_q;
  assign bank0_line_out = line_out_q[7:0];
  assign bank1_line_out = line_out_q[15:8];
  assign bank0_line_oe_n_out = line_oe_n_q[7:0];
  assign bank1_line_oe_n_out = line_oe_n_q[15:8];
  assign bank0_hold_en_out = hold_en_q[7:0];
  assign bank1_hold_en_out = hold_en_q[15:8];
  assign bank0_hold_level_out = hold_q[7:0];
  assign bank1_hold_level_out = hold_q[15:8];
  assign bank0_pull_up_en_out = pu_q[7:0];
  assign bank1_pull_up_en_out = pu_q[15:8];
  assign bank0_pull_down_en_out = pd_q[7:0];
  assign bank1_pull_down_en_out = pd_q[15:8];

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  a_keeper_pull_excl: assert property (
    (hold_en_q & (pu_q | pd_q)) == '0)
    else $error("keeper and pull active together");
  a_ptr_advance: assert property (
    (wr_commit || rd_commit) && ptr_q[AUTOADVANCE_BIT] |=>
    ptr_q[3:0] == $past(ptr_q[3:0]) + POINTER_STEP)
    else $error("pointer did not advance");
  a_ptr_hold: assert property (
    (wr_commit || rd_commit) && !ptr_q[AUTOADVANCE_BIT] && !cmd_take |=>
    $stable(ptr_q))
    else $error("pointer moved without auto-advance");
  a_bad_cmd_nack: assert property (
    scl_fall && !hw_rst_active && state_q == ST_CMD &&
    cnt_q == BIT_COUNT_FULL && !cmd_ok |=>
    state_q == ST_IDLE && sda_oe_n_out)
    else $error("reserved command acknowledged");
  a_flags_readonly: assert property (
    wr_commit && idx >= IDX_ALERT_FLAGS0 && set_v == '0 |=>
    flags_q == $past(flags_q))
    else $error("write changed alert flags");
  a_masked_quiet: assert property (
    ((flags_q & ~$past(flags_q)) & $past(mask_v)) == '0)
    else $error("masked line raised a flag");
  a_int_follows: assert property (
    (|flags_q) |=> !int_oe_n_out)
    else $error("alert not asserted");
  a_read_invert: assert property (
    scl_fall && !hw_rst_active && state_q == ST_ADDR_ACK && rw_q &&
    idx == IDX_PIN_LEVELS0 |=>
    sda_oe_n_out == $past(pins[7] ^ inv_v[7]))
    else $error("first read bit not inverted properly");
  a_dir_to_pad: assert property (
    wr_commit && idx == IDX_LINE_DIR0 |=> ##1
    bank0_line_oe_n_out == $past(rx_q, 2))
    else $error("direction write did not reach pads");
  a_hw_reset_init: assert property (
    hw_rst_active |=> ptr_q == POINTER_RESET && state_q == ST_IDLE &&
    dir_v == {DIRECTION_RESET, DIRECTION_RESET})
    else $error("hardware reset incomplete");

  c_write: cover property (wr_commit);
  c_read: cover property (rd_load ##[1:400] rd_commit);
  c_flag: cover property (set_v != '0);
  c_bad_cmd: cover property (scl_fall && state_q == ST_CMD &&
    cnt_q == BIT_COUNT_FULL && !cmd_ok);

endmodule

`default_nettype wire

/* File: pkg/expander_pkg.sv */
package expander_pkg;

  localparam int NUM_LINES = 16;
  localparam int BANK_WIDTH = 8;

  // register indices
  localparam logic [3:0] IDX_PIN_LEVELS0 = 4'h0;
  localparam logic [3:0] IDX_PIN_LEVELS1 = 4'h1;
  localparam logic [3:0] IDX_READ_INVERT0 = 4'h2;
  localparam logic [3:0] IDX_READ_INVERT1 = 4'h3;
  localparam logic [3:0] IDX_KEEPER_PULL0 = 4'h4;
  localparam logic [3:0] IDX_KEEPER_PULL1 = 4'h5;
  localparam logic [3:0] IDX_PULL_DIR0 = 4'h6;
  localparam logic [3:0] IDX_PULL_DIR1 = 4'h7;
  localparam logic [3:0] IDX_LINE_DIR0 = 4'h8;
  localparam logic [3:0] IDX_LINE_DIR1 = 4'h9;
  localparam logic [3:0] IDX_DRIVE_VALUE0 = 4'hA;
  localparam logic [3:0] IDX_DRIVE_VALUE1 = 4'hB;
  localparam logic [3:0] IDX_ALERT_MASK0 = 4'hC;
  localparam logic [3:0] IDX_ALERT_MASK1 = 4'hD;
  localparam logic [3:0] IDX_ALERT_FLAGS0 = 4'hE;
  localparam logic [3:0] IDX_ALERT_FLAGS1 = 4'hF;

  // reset values; direction bit 1 means input
  localparam logic [7:0] INVERT_RESET = 8'h00;
  localparam logic [7:0] KEEPER_PULL_RESET = 8'h00;
  localparam logic [7:0] PULL_DIR_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'hFF;
  localparam logic [7:0] DRIVE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] POINTER_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // command byte and keeper/pull register fields
  localparam int AUTOADVANCE_BIT = 7;
  localparam logic [7:0] CMD_RESERVED_MASK = 8'h70;
  localparam int KEEPER_EN_BIT = 0;
  localparam int PULL_EN_BIT = 1;

  // slave address; both values arbitrary
  localparam logic [6:0] FIXED_SLAVE_ADDR = 7'h2A;
  localparam logic [2:0] STRAP_ADDR_BASE = 3'h5;

  localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
  localparam logic [3:0] BIT_COUNT_ONE = 4'h1;
  localparam logic [3:0] POINTER_STEP = 4'h1;

  // synchroniser layout
  localparam int SYNC_WIDTH = 24;
  localparam int SYNC_HW_RST_BIT = 23;
  localparam int SYNC_VARIANT_BIT = 22;
  localparam int SYNC_ADDR_HI = 21;
  localparam int SYNC_ADDR_LO = 18;
  localparam int SYNC_SCL_BIT = 17;
  localparam int SYNC_SDA_BIT = 16;
  localparam logic [23:0] SYNC_RESET = 24'h830000;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } xfer_state_t;

  function automatic logic [7:0] reset_value(input logic [3:0] idx);
    case (idx)
      IDX_READ_INVERT0, IDX_READ_INVERT1: reset_value = INVERT_RESET;
      IDX_KEEPER_PULL0, IDX_KEEPER_PULL1: reset_value = KEEPER_PULL_RESET;
      IDX_PULL_DIR0, IDX_PULL_DIR1: reset_value = PULL_DIR_RESET;
      IDX_LINE_DIR0, IDX_LINE_DIR1: reset_value = DIRECTION_RESET;
      IDX_DRIVE_VALUE0, IDX_DRIVE_VALUE1: reset_value = DRIVE_RESET;
      IDX_ALERT_MASK0, IDX_ALERT_MASK1: reset_value = MASK_RESET;
      default: reset_value = BYTE_ZERO;
    endcase
  endfunction

endpackage

/* File: testbench/i2c_master_model.sv */
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
  // bus wires; sda_pull_out high means the master pulls sda low
  output logic scl_out,
  output logic sda_pull_out,
  input wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  // sda moves only once the device has surely seen scl low
  task automatic bit_xfer(input logic b, output logic r);
    #250 sda_pull_out = ~b;
    #50 scl_out = 1'b1;
    #90 r = sda_in;
    #10 scl_out = 1'b0;
  endtask

  task automatic start_cond();
    if (scl_out === 1'b0) begin
      #250 sda_pull_out = 1'b0;
      #50 scl_out = 1'b1;
    end
    #200 sda_pull_out = 1'b1;
    #200 scl_out = 1'b0;
  endtask

  // scl stands high after a stop, the bus idles released
  task automatic stop_cond();
    #250 sda_pull_out = 1'b1;
    #50 scl_out = 1'b1;
    #200 sda_pull_out = 1'b0;
    #200;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], r);
    end
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask

  // last byte of a read is refused so the device lets go
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, d[i]);
    end
    bit_xfer(last, r);
  endtask
endmodule

`default_nettype wire

/* File: testbench/i2c_gpio_expander_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module i2c_gpio_expander_core_tb;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic hw_rst_n = 1'b1;
  logic variant = 1'b0;
  logic [3:0] asel = 4'h0;
  logic [7:0] ext0 = 8'h00;
  logic [7:0] ext1 = 8'h00;
  logic [7:0] een0 = 8'hFF;
  logic [7:0] een1 = 8'hFF;
  logic tog = 1'b0;
  wire scl;
  wire m_pull;
  wire sda;
  logic sda_o, sda_oe_n, int_o, int_oe_n;
  logic [7:0] in0, o0, oe0_n, he0, hl0, pu0, pd0;
  logic [7:0] in1, o1, oe1_n, he1, hl1, pu1, pd1;
  logic [7:0] mreg [16];
  int ptr;
  logic ai;
  logic [6:0] dev_addr = 7'h2A;
  int fail_count = 0;
  int check_count = 0;

  always #25 clock_in = ~clock_in;
  // floating lines wander so a missing pull never reads as stable
  always @(negedge clock_in) tog <= ~tog;

  function automatic logic [7:0] res(input logic [7:0] oe_n, o, ee, e,
                                     he, hl, pu, pd, input logic t);
    logic [7:0] fl;
    fl = oe_n & ~ee & ~he;
    res = (~oe_n & o) | (oe_n & ee & e) | (oe_n & ~ee & he & hl) |
          (fl & pu) | (fl & ~pu & ~pd & {8{t}});
  endfunction

  // device side drives its data value only while enabled
  assign sda = m_pull ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);
  assign in0 = res(oe0_n, o0, een0, ext0, he0, hl0, pu0, pd0, tog);
  assign in1 = res(oe1_n, o1, een1, ext1, he1, hl1, pu1, pd1, ~tog);

  i2c_master_model i_master (
    .scl_out(scl), .sda_pull_out(m_pull), .sda_in(sda));

  i2c_gpio_expander_core i_dut (
    .clock_in(clock_in), .rst_in(rst_in), .hw_reset_n_in(hw_rst_n),
    .variant_28pin_in(variant), .addr_select_0_in(asel[0]),
    .addr_select_1_in(asel[1]), .addr_select_2_in(asel[2]),
    .addr_select_3_in(asel[3]), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
    .bank0_line_in(in0), .bank0_line_out(o0), .bank0_line_oe_n_out(oe0_n),
    .bank0_hold_en_out(he0), .bank0_hold_level_out(hl0),
    .bank0_pull_up_en_out(pu0), .bank0_pull_down_en_out(pd0),
    .bank1_line_in(in1), .bank1_line_out(o1), .bank1_line_oe_n_out(oe1_n),
    .bank1_hold_en_out(he1), .bank1_hold_level_out(hl1),
    .bank1_pull_up_en_out(pu1), .bank1_pull_down_en_out(pd1),
    .int_out(int_o), .int_oe_n_out(int_oe_n));

  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  task automatic model_reset();
    foreach (mreg[i]) mreg[i] = 8'h00;
    mreg[8] = 8'hFF;
    mreg[9] = 8'hFF;
    mreg[12] = 8'hFF;
    mreg[13] = 8'hFF;
    ptr = 0;
    ai = 1'b0;
  endtask

  function automatic logic [7:0] lvl(input int b);
    logic [7:0] e;
    e = (b == 0) ? ext0 : ext1;
    lvl = (~mreg[8 + b] & mreg[10 + b]) | (mreg[8 + b] & e);
  endfunction

  function automatic logic [7:0] exp_val(input int idx);
    exp_val = (idx < 2) ? lvl(idx) ^ mreg[2 + idx] : mreg[idx];
  endfunction

  task automatic step();
    if (ai) begin
      ptr = (ptr + 1) % 16;
    end
  endtask

  task automatic open_cmd(input logic [7:0] cmd);
    logic a;
    i_master.start_cond();
    i_master.send_byte({dev_addr, 1'b0}, a);
    chk({7'h0, a}, 8'h01); // address taken
    i_master.send_byte(cmd, a);
    chk({7'h0, a}, 8'h01); // command taken
    ptr = cmd[3:0];
    ai = cmd[7];
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] q[$]);
    logic a;
    open_cmd(cmd);
    foreach (q[k]) begin
      i_master.send_byte(q[k], a);
      chk({7'h0, a}, 8'h01); // data taken
      if (ptr >= 2 && ptr <= 13) begin
        mreg[ptr] = q[k];
      end
      step();
    end
    i_master.stop_cond();
  endtask

  task automatic rd(input logic [7:0] cmd, input logic use_cmd, input int n);
    logic a;
    logic [7:0] d;
    if (use_cmd) begin
      open_cmd(cmd);
    end
    i_master.start_cond();
    i_master.send_byte({dev_addr, 1'b1}, a);
    chk({7'h0, a}, 8'h01); // read address
    for (int k = 0; k < n; k++) begin
      i_master.get_byte(k == n - 1, d);
      chk(d, exp_val(ptr)); // read data
      if (ptr < 2) begin
        mreg[14 + ptr] = 8'h00;
      end
      step();
    end
    i_master.stop_cond();
  endtask

  task automatic chk_bank(input logic [7:0] oe_n, o, he, pu, pd, input int b);
    logic [7:0] en;
    en = mreg[8 + b] & {8{~mreg[4 + b][0] & mreg[4 + b][1]}};
    chk(oe_n, mreg[8 + b]); // direction
    chk(o, mreg[10 + b]); // drive value
    chk(he, mreg[8 + b] & {8{mreg[4 + b][0]}}); // keeper enable
    chk(pu, en & mreg[6 + b]); // pull up
    chk(pd, en & ~mreg[6 + b]); // pull down
  endtask

  task automatic chk_pads();
    w(4);
    chk_bank(oe0_n, o0, he0, pu0, pd0, 0); // bank zero
    chk_bank(oe1_n, o1, he1, pu1, pd1, 1); // bank one
    chk(hl0, lvl(0)); // keeper tracks driven level
  endtask

  initial begin
    logic [7:0] q[$];
    logic a;
    int s;
    void'($urandom(23315));
    ext0 = $urandom;
    ext1 = $urandom;
    w(6);
    rst_in = 1'b0;
    w(10);
    model_reset();
    rd(8'h00, 1'b0, 2); // pointer at zero
    rd(8'h83, 1'b1, 16); // defaults and wrap
    chk_pads(); // inputs after reset
    s = $urandom_range(15, 0);
    for (int k = 0; k < 16; k++) begin
      q.push_back(((s + k) % 16 inside {12, 13}) ? 8'hFF : 8'($urandom));
    end
    wr(8'h80 | 8'(s), q); // burst with wrap
    chk_pads(); // each register lands alone
    rd(8'h80, 1'b1, 16); // readback
    wr(8'h0A, '{8'h11, 8'h22, 8'h33}); // same register
    rd(8'h8A, 1'b1, 2); // neighbour untouched
    for (int p = 1; p < 8; p++) begin
      i_master.start_cond();
      i_master.send_byte({dev_addr, 1'b0}, a);
      i_master.send_byte({1'b1, 3'(p), 4'h2}, a);
      chk({7'h0, a}, 8'h00); // reserved refused
      i_master.stop_cond();
    end
    w(2);
    variant = 1'b1;
    asel = 4'($urandom);
    w(10);
    i_master.start_cond();
    i_master.send_byte({7'h2A, 1'b0}, a);
    chk({7'h0, a}, 8'h00); // fixed address ignored
    i_master.stop_cond();
    dev_addr = {3'b101, asel};
    rd(8'h02, 1'b1, 1); // strapped address
    wr(8'h09, '{8'hFF});
    wr(8'h05, '{8'h01});
    w(10);
    een1 = 8'h00;
    w(10);
    chk(hl1, ext1); // keeper holds last level
    chk_pads(); // keeper on
    rd(8'h01, 1'b1, 1); // held level read
    wr(8'h05, '{8'h02});
    wr(8'h07, '{8'h0F});
    chk_pads(); // pulls without keeper
    ext1 = 8'h0F;
    rd(8'h01, 1'b1, 1); // pulled level read
    een1 = 8'hFF;
    wr(8'h08, '{8'hFF});
    wr(8'h0C, '{8'hFE});
    w(10);
    ext0[1] = ~ext0[1];
    w(15);
    chk({7'h0, int_oe_n}, 8'h01); // masked change quiet
    ext0[0] = ~ext0[0];
    mreg[14] = 8'h01;
    w(15);
    chk({int_o, int_oe_n}, 8'h00); // alert pulled low
    rd(8'h0E, 1'b1, 1); // flag set
    rd(8'h00, 1'b1, 1); // input read clears
    w(5);
    chk({7'h0, int_oe_n}, 8'h01); // alert released
    hw_rst_n = 1'b0;
    w(8);
    hw_rst_n = 1'b1;
    w(12);
    model_reset();
    chk_pads(); // pin reset
    rd(8'h80, 1'b1, 16); // defaults again
    wrap_up();
  end

  initial begin
    #3000000;
    fail_count++;
    wrap_up();
  end
endmodule

`default_nettype wire
